// file: src/adc_seq_defs.svh
`ifndef ADC_SEQ_DEFS_SVH
`define ADC_SEQ_DEFS_SVH
// Overview of operation
// R1 - Conversion starts only when start bit is written while the converter is enabled.
// R2 - Enabling write does not start a conversion in the same instruction.
// R3 - At end: clear busy, set done flag, load high and low results.
// R4 - Reset turns converter off and abandons any conversion.
// R5 - Conversions continue through sleep only with dedicated RC clock selected.
// R6 - With RC clock, start is delayed by one extra instruction cycle.
// R7 - In sleep with interrupt enabled, completion wakes the device.
// R8 - In sleep with interrupt disabled, power down after completion, enable stays 1.
// R9 - Non-RC clock: sleep aborts conversion and powers down, enable stays set.
// R10 - Rising edge on selected trigger source sets the busy bit in hardware.
// R11 - Trigger code 0x00 disables, 0x01 selects mapped pin, 0x13 up reserved.
// R12 - Codes 0x02 to 0x12 map timers, captures, PWMs, oscillator, comparators, cells.
// R13 - Trigger edges are ignored while in sleep.
// R14 - Software keeps hardware trigger rates within converter timing.
// R15 - Software allows acquisition time after a channel change.
// R16 - Software configures, enables, waits acquisition, starts, reads after completion.
// R17 - Software polls busy or takes interrupt, then clears the done flag.
// R18 - Hold capacitor is not discharged after a conversion.
// R19 - Only software clears done flag; hardware sets it after every conversion.
// R20 - One conversion lasts eleven and a half bit-conversion periods.
// R21 - Right justify zeroes upper six high bits; left justify zeroes lower six low bits.
// R22 - Start requests during a running conversion are ignored.
// R23 - Clearing enable aborts, clears busy, keeps results.

// ----------------------------------------
// Trigger codes
// ----------------------------------------
`define TRIG_OFF 5'h00
`define TRIG_PIN 5'h01
`define TRIG_LAST 5'h12
`define TRIG_COUNT 19

// ----------------------------------------
// Clock select codes
// ----------------------------------------
`define CLK_RC_LOW 2'h3

// ----------------------------------------
// Timing
// ----------------------------------------
`define HALF_PERIODS 5'h17
// Rest of the starting instruction plus one more
`define INSTR_CYCLES 3'h2
`define RC_TAD_NS 2000
`define CLK_PERIOD_NS 100
`define RC_DIV ((`RC_TAD_NS / 2) / `CLK_PERIOD_NS)
`endif

// file: src/adc_seq_pkg.sv
package adc_seq_pkg;
   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_DELAY = 4'h2,
      ST_CONV = 4'h4,
      ST_OFF = 4'h8
   } conv_state_e;
   typedef logic [9:0] sample_t;
endpackage

// file: src/adc_tad_divider.sv
`timescale 1ns/1ps
`include "adc_seq_defs.svh"
module adc_tad_divider
   import adc_seq_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset,
   input wire logic run,
   input wire logic [2:0] clock_select,
   output logic half_tick
);
   // ----------------------------------------
   // Half bit-period tick generator
   // ----------------------------------------
   logic [7:0] count;
   logic [7:0] next_count;
   logic [7:0] limit;

   always_comb begin
      case (clock_select)
         3'h0: limit = 8'h00;
         3'h4: limit = 8'h01;
         3'h1: limit = 8'h03;
         3'h5: limit = 8'h07;
         3'h2: limit = 8'h0F;
         3'h6: limit = 8'h1F;
         default: limit = 8'(`RC_DIV - 1);
      endcase
      if (!run || count >= limit) begin
         next_count = 8'h00;
      end else begin
         next_count = count + 8'h01;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         count <= 8'h00;
      end else begin
         count <= next_count;
      end
   end

   assign half_tick = run && (count >= limit);
endmodule

// file: src/adc_conversion_sequencer.sv
`timescale 1ns/1ps
`include "adc_seq_defs.svh"
module adc_conversion_sequencer
   import adc_seq_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset,
   input wire logic instr_tick,
   input wire logic enable_write,
   input wire logic enable_wdata,
   input wire logic start_write,
   input wire logic start_wdata,
   input wire logic [2:0] clock_select,
   input wire logic result_justify,
   input wire logic [4:0] trigger_select,
   input wire logic [`TRIG_COUNT-1:0] trigger_sources,
   input wire logic conversion_irq_enable,
   input wire logic sleep_active,
   input wire logic done_clear,
   input wire logic [9:0] sample_value,
   output logic converter_enable,
   output logic start_busy_flag,
   output logic conversion_done_flag,
   output logic [7:0] result_high,
   output logic [7:0] result_low,
   output logic converter_powered,
   output logic wake_request
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   conv_state_e state;
   conv_state_e next_state;
   logic next_converter_enable;
   logic next_start_busy_flag;
   logic next_conversion_done_flag;
   logic [7:0] next_result_high;
   logic [7:0] next_result_low;
   logic next_wake_request;
   logic [4:0] halves;
   logic [4:0] next_halves;
   logic [2:0] delay_left;
   logic [2:0] next_delay_left;
   logic trig_prev;
   logic next_trig_prev;
   logic trig_level;
   logic trig_edge;
   logic rc_clock;
   logic half_tick;
   logic start_req;
   logic sw_start;

   assign rc_clock = (clock_select[1:0] == `CLK_RC_LOW);

   // ----------------------------------------
   // Trigger selection
   // ----------------------------------------
   always_comb begin
      if (trigger_select == `TRIG_OFF || trigger_select > `TRIG_LAST) begin
         trig_level = 1'b0; // R11
      end else begin
         trig_level = trigger_sources[trigger_select]; // R12
      end
   end
   assign trig_edge = trig_level && !trig_prev && !sleep_active; // R10 R13

   // Enable must already be set before the start write
   assign sw_start = start_write && start_wdata && converter_enable; // R1 R2
   assign start_req = (sw_start || (trig_edge && converter_enable)) && state == ST_IDLE; // R22

   adc_tad_divider divider (
      .core_clk(core_clk),
      .reset(reset),
      .run(state == ST_CONV),
      .clock_select(clock_select),
      .half_tick(half_tick)
   );

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   always_comb begin
      next_state = state;
      next_converter_enable = converter_enable;
      next_start_busy_flag = start_busy_flag;
      next_conversion_done_flag = conversion_done_flag;
      next_result_high = result_high; // R18
      next_result_low = result_low;
      next_wake_request = 1'b0;
      next_halves = halves;
      next_delay_left = delay_left;
      next_trig_prev = trig_level;
      if (done_clear) begin
         next_conversion_done_flag = 1'b0;
      end
      if (enable_write) begin
         next_converter_enable = enable_wdata;
      end
      case (state)
         ST_IDLE: begin
            if (start_req) begin
               next_start_busy_flag = 1'b1;
               next_halves = 5'h00;
               if (rc_clock) begin
                  next_delay_left = `INSTR_CYCLES; // R6
                  next_state = ST_DELAY;
               end else begin
                  next_state = ST_CONV;
               end
            end else if (start_write && !start_wdata) begin
               next_start_busy_flag = 1'b0;
            end
         end
         ST_DELAY: begin
            if (instr_tick) begin
               next_delay_left = delay_left - 3'h1;
               if (delay_left == 3'h1) begin
                  next_state = ST_CONV;
               end
            end
         end
         ST_CONV: begin
            if (half_tick) begin
               next_halves = halves + 5'h01;
               if (halves == `HALF_PERIODS - 5'h01 && !(enable_write && !enable_wdata)) begin // R20 R23
                  next_start_busy_flag = 1'b0; // R3
                  next_conversion_done_flag = 1'b1; // R3 R19
                  if (result_justify) begin // R21
                     next_result_high = {6'h00, sample_value[9:8]};
                     next_result_low = sample_value[7:0];
                  end else begin
                     next_result_high = sample_value[9:2];
                     next_result_low = {sample_value[1:0], 6'h00};
                  end
                  next_wake_request = sleep_active && conversion_irq_enable; // R7
                  next_state = (sleep_active && !conversion_irq_enable) ? ST_OFF : ST_IDLE; // R8
               end
            end
         end
         ST_OFF: begin
            if (!sleep_active) begin
               next_state = ST_IDLE;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
      // R5 R9
      if (sleep_active && !rc_clock && (state == ST_CONV || state == ST_DELAY)) begin
         next_start_busy_flag = 1'b0;
         next_state = ST_OFF;
      end
      if (enable_write && !enable_wdata) begin // R23
         next_start_busy_flag = 1'b0;
         next_state = ST_IDLE;
      end
   end

   // Results persist; nothing discharges between conversions
   always_ff @(posedge core_clk) begin
      if (reset) begin // R4
         state <= ST_IDLE;
         converter_enable <= 1'b0;
         start_busy_flag <= 1'b0;
         conversion_done_flag <= 1'b0;
         result_high <= 8'h00;
         result_low <= 8'h00;
         wake_request <= 1'b0;
         halves <= 5'h00;
         delay_left <= 3'h0;
         trig_prev <= 1'b0;
      end else begin
         state <= next_state;
         converter_enable <= next_converter_enable;
         start_busy_flag <= next_start_busy_flag;
         conversion_done_flag <= next_conversion_done_flag;
         result_high <= next_result_high;
         result_low <= next_result_low;
         wake_request <= next_wake_request;
         halves <= next_halves;
         delay_left <= next_delay_left;
         trig_prev <= next_trig_prev;
      end
   end

   assign converter_powered = converter_enable && state != ST_OFF;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   chk_done_sets: assert property (@(posedge core_clk) disable iff (reset)
      (state == ST_CONV && half_tick && halves == 5'h16 && !(enable_write && !enable_wdata)
       && !(sleep_active && !rc_clock)) |=> conversion_done_flag && !start_busy_flag) // R3
      else $error("done not signalled at conversion end");
   chk_reset_off: assert property (@(posedge core_clk) reset |=> !converter_enable
      && !start_busy_flag && state == ST_IDLE) // R4
      else $error("reset did not turn converter off");
   chk_start_enabled: assert property (@(posedge core_clk) disable iff (reset)
      ($rose(start_busy_flag)) |-> $past(converter_enable)) // R1
      else $error("start without enable");
   chk_rc_delay: assert property (@(posedge core_clk) disable iff (reset)
      (state == ST_IDLE && start_req && rc_clock) |=> state == ST_DELAY) // R6
      else $error("rc start not delayed");
   chk_sleep_abort: assert property (@(posedge core_clk) disable iff (reset)
      (sleep_active && !rc_clock && state == ST_CONV && !(enable_write && !enable_wdata))
      |=> state == ST_OFF && !start_busy_flag) // R9
      else $error("sleep did not abort");
   chk_sleep_trig: assert property (@(posedge core_clk) disable iff (reset)
      (sleep_active && state == ST_IDLE && !start_write) |=> !$rose(start_busy_flag)) // R13
      else $error("trigger honoured in sleep");
   chk_disable_abort: assert property (@(posedge core_clk) disable iff (reset)
      (enable_write && !enable_wdata) |=> !start_busy_flag && $stable(result_high)) // R23
      else $error("disable did not abort");
   chk_done_hold: assert property (@(posedge core_clk) disable iff (reset)
      (conversion_done_flag && !done_clear) |=> conversion_done_flag) // R19
      else $error("done flag dropped by hardware");
   chk_justify: assert property (@(posedge core_clk) disable iff (reset)
      ($rose(conversion_done_flag) && $past(result_justify)) |-> result_high[7:2] == 6'h00) // R21
      else $error("justify zero bits wrong");
   chk_trig_start: assert property (@(posedge core_clk) disable iff (reset)
      (state == ST_IDLE && converter_enable && !sleep_active && trigger_select != `TRIG_OFF
       && trigger_select <= `TRIG_LAST && trigger_sources[trigger_select]
       && !$past(trigger_sources[trigger_select]) && $stable(trigger_select)
       && !(enable_write && !enable_wdata)) |=> start_busy_flag) // R10
      else $error("trigger edge did not start");
   chk_reserved_off: assert property (@(posedge core_clk) disable iff (reset)
      (state == ST_IDLE && (trigger_select == `TRIG_OFF || trigger_select > `TRIG_LAST)
       && !(start_write && start_wdata)) |=> !start_busy_flag) // R11
      else $error("disabled trigger code started");
   chk_no_early_start: assert property (@(posedge core_clk) disable iff (reset)
      (!converter_enable && state == ST_IDLE) |=> !start_busy_flag) // R2
      else $error("start in enabling write");
   chk_busy_ignore: assert property (@(posedge core_clk) disable iff (reset)
      (state == ST_CONV && start_write && start_wdata && !enable_write && !sleep_active
       && !(half_tick && halves == 5'h16))
      |=> state == ST_CONV && start_busy_flag && halves == $past(halves + {4'h0, half_tick})) // R22
      else $error("start disturbed running conversion");
   chk_rc_hold: assert property (@(posedge core_clk) disable iff (reset)
      (sleep_active && rc_clock && state == ST_CONV && !(enable_write && !enable_wdata)
       && !(half_tick && halves == 5'h16)) |=> state == ST_CONV && start_busy_flag) // R5
      else $error("rc conversion stopped in sleep");
   chk_results_hold: assert property (@(posedge core_clk) disable iff (reset)
      !(state == ST_CONV && half_tick && halves == 5'h16 && !(enable_write && !enable_wdata))
      |=> $stable(result_high) && $stable(result_low)) // R18
      else $error("results changed between conversions");
   cov_sw_conv: cover property (@(posedge core_clk) disable iff (reset)
      $fell(start_busy_flag) && conversion_done_flag);
   cov_wake: cover property (@(posedge core_clk) disable iff (reset) wake_request);
   cov_off: cover property (@(posedge core_clk) disable iff (reset) state == ST_OFF);
   cov_trig_conv: cover property (@(posedge core_clk) disable iff (reset)
      state == ST_IDLE && trig_edge && converter_enable);
   cov_rc_delay: cover property (@(posedge core_clk) disable iff (reset)
      state == ST_DELAY && instr_tick);
endmodule

// file: verification/trigger_source_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Peripheral trigger sources
// ----------------------------------------
module trigger_source_model (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic fire,
   input wire logic [4:0] code,
   output logic [18:0] sources
);
   logic [1:0] hold;
   // One short pulse per request, so triggers stay slow
   always @(posedge core_clk) begin
      if (reset || hold == 2'h1) begin
         sources <= 19'h0;
         hold <= 2'h0;
      end else if (fire) begin
         sources <= 19'h1 << code;
         hold <= 2'h3;
      end else if (hold != 2'h0) begin
         hold <= hold - 2'h1;
      end
   end
endmodule

// file: verification/adc_conversion_sequencer_bench.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin failures++; \
   $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module adc_conversion_sequencer_bench;
   typedef struct {logic [9:0] v; logic j; logic [7:0] hi; logic [7:0] lo;} row_s;
   row_s rows [4] = '{'{10'h3FF, 1'b1, 8'h03, 8'hFF}, '{10'h3FF, 1'b0, 8'hFF, 8'hC0},
      '{10'h2A5, 1'b1, 8'h02, 8'hA5}, '{10'h2A5, 1'b0, 8'hA9, 8'h40}};
   logic [4:0] sel [3] = '{5'h00, 5'h02, 5'h13};
   logic [4:0] src [3] = '{5'h00, 5'h03, 5'h12};
   logic [2:0] clk_code [6] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6};
   logic core_clk = 1'b0, reset = 1'b1, instr_tick = 1'b0, enable_write = 1'b0;
   logic enable_wdata = 1'b0, start_write = 1'b0, start_wdata = 1'b0, result_justify = 1'b0;
   logic conversion_irq_enable = 1'b0, sleep_active = 1'b0, done_clear = 1'b0, fire = 1'b0;
   logic [2:0] clock_select = 3'h0;
   logic [4:0] trigger_select = 5'h00, fire_code = 5'h00;
   logic [18:0] trigger_sources;
   logic [9:0] sample_value = 10'h000;
   logic [1:0] phase = 2'h0;
   logic converter_enable, start_busy_flag, conversion_done_flag, converter_powered;
   logic wake_request, woke;
   logic [7:0] result_high, result_low;
   int failures = 0, n_compared = 0, cycles = 0, n;

   adc_conversion_sequencer uut (.core_clk(core_clk), .reset(reset), .instr_tick(instr_tick),
      .enable_write(enable_write), .enable_wdata(enable_wdata), .start_write(start_write),
      .start_wdata(start_wdata), .clock_select(clock_select), .result_justify(result_justify),
      .trigger_select(trigger_select), .trigger_sources(trigger_sources),
      .conversion_irq_enable(conversion_irq_enable), .sleep_active(sleep_active),
      .done_clear(done_clear), .sample_value(sample_value), .converter_enable(converter_enable),
      .start_busy_flag(start_busy_flag), .conversion_done_flag(conversion_done_flag),
      .result_high(result_high), .result_low(result_low),
      .converter_powered(converter_powered), .wake_request(wake_request));
   trigger_source_model triggers (.core_clk(core_clk), .reset(reset), .fire(fire),
      .code(fire_code), .sources(trigger_sources));

   // ----------------------------------------
   // Clock, instruction tick, timeout
   // ----------------------------------------
   always #50 core_clk = ~core_clk;
   always @(negedge core_clk) begin
      phase <= phase + 2'h1;
      instr_tick <= (phase == 2'h3);
   end
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 30000) begin
         failures++;
         complete_run();
      end
   end

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic complete_run();
      $display("compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic pulse_start();
      @(negedge core_clk);
      start_write = 1'b1;
      start_wdata = 1'b1;
      @(negedge core_clk);
      start_write = 1'b0;
   endtask
   task automatic set_enable(input logic v);
      @(negedge core_clk);
      enable_write = 1'b1;
      enable_wdata = v;
      @(negedge core_clk);
      enable_write = 1'b0;
   endtask
   task automatic clear_done();
      @(negedge core_clk);
      done_clear = 1'b1;
      @(negedge core_clk);
      done_clear = 1'b0;
   endtask
   task automatic trig(input logic [4:0] c);
      @(negedge core_clk);
      fire_code = c;
      fire = 1'b1;
      @(negedge core_clk);
      fire = 1'b0;
   endtask
   // Counts busy cycles; a second start may be poked mid-conversion
   task automatic measure(input int poke);
      n = 0;
      woke = 1'b0;
      repeat (4) if (start_busy_flag !== 1'b1) @(negedge core_clk);
      while (start_busy_flag === 1'b1 && n < 800) begin
         start_write = (n == poke);
         if (wake_request === 1'b1) woke = 1'b1;
         @(negedge core_clk);
         n++;
      end
      start_write = 1'b0;
      repeat (3) begin
         if (wake_request === 1'b1) woke = 1'b1;
         @(negedge core_clk);
      end
   endtask

   // ----------------------------------------
   // Sequence
   // ----------------------------------------
   initial begin
      repeat (12) @(negedge core_clk);
      reset = 1'b0;
      `CHK({converter_enable, start_busy_flag, conversion_done_flag, result_high, result_low}, 19'h0)
      set_enable(1'b1);
      foreach (rows[i]) begin
         sample_value = rows[i].v;
         result_justify = rows[i].j;
         repeat (4) @(negedge core_clk);
         pulse_start();
         measure(i == 1 ? 5 : -1);
         `CHK(n, 23)
         repeat (5) @(negedge core_clk);
         `CHK(conversion_done_flag, 1'b1)
         `CHK({result_high, result_low}, {rows[i].hi, rows[i].lo})
         clear_done();
         `CHK(conversion_done_flag, 1'b0)
      end
      for (int k = 0; k < 6; k++) begin
         clock_select = clk_code[k];
         pulse_start();
         measure(-1);
         `CHK(n, 23 << k)
      end
      clock_select = 3'h0;
      for (int c = 1; c <= 18; c++) begin
         trigger_select = c[4:0];
         trig(c[4:0]);
         measure(-1);
         `CHK(n, 23)
      end
      for (int k = 0; k < 3; k++) begin
         trigger_select = sel[k];
         trig(src[k]);
         measure(-1);
         `CHK(n, 0)
      end
      trigger_select = 5'h02;
      sleep_active = 1'b1;
      trig(5'h02);
      measure(-1);
      `CHK(n, 0)
      sleep_active = 1'b0;
      pulse_start();
      repeat (5) @(negedge core_clk);
      sleep_active = 1'b1;
      repeat (3) @(negedge core_clk);
      `CHK({start_busy_flag, converter_powered, converter_enable}, 3'h1)
      sleep_active = 1'b0;
      pulse_start();
      repeat (5) @(negedge core_clk);
      set_enable(1'b0);
      repeat (30) @(negedge core_clk);
      `CHK({start_busy_flag, result_high, result_low}, 17'h0A940)
      pulse_start();
      measure(-1);
      `CHK(n, 0)
      enable_write = 1'b1;
      enable_wdata = 1'b1;
      start_write = 1'b1;
      @(negedge core_clk);
      enable_write = 1'b0;
      start_write = 1'b0;
      measure(-1);
      `CHK({n == 0, converter_enable}, 2'h3)
      clear_done();
      clock_select = 3'h3;
      conversion_irq_enable = 1'b1;
      pulse_start();
      sleep_active = 1'b1;
      measure(-1);
      `CHK((n >= 235 && n <= 238), 1'b1)
      `CHK({woke, conversion_done_flag}, 2'h3)
      sleep_active = 1'b0;
      clear_done();
      conversion_irq_enable = 1'b0;
      pulse_start();
      sleep_active = 1'b1;
      measure(-1);
      `CHK({woke, conversion_done_flag, converter_powered, converter_enable}, 4'h5)
      sleep_active = 1'b0;
      clock_select = 3'h0;
      pulse_start();
      repeat (5) @(negedge core_clk);
      reset = 1'b1;
      @(negedge core_clk);
      reset = 1'b0;
      `CHK({converter_enable, start_busy_flag, conversion_done_flag, result_high, result_low}, 19'h0)
      complete_run();
   end
endmodule
